// file: hw/eia_pkg.sv
package eia_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_ENH = 8'h6c;
  localparam logic [7:0] ADDR_IDATA = 8'h70;
  localparam logic [7:0] ADDR_IADDR = 8'h74;
  localparam logic [7:0] ADDR_STATUS = 8'h78;
  localparam logic [7:0] ADDR_CTRL = 8'h7c;
  localparam logic [7:0] ADDR_LOOP_CURRENT_LIMIT = 8'h80;
  // Enhancement field positions
  localparam int BIT_BOOST = 7;
  localparam int BIT_FSK = 6;
  localparam int BIT_SPEEDUP = 5;
  localparam int BIT_EXTREF = 4;
  localparam int BIT_DEBOUNCE = 3;
  localparam int BIT_VLC = 2;
  localparam int BIT_SQUELCH = 1;
  localparam int BIT_HYST = 0;
  // Control register fields
  localparam int BIT_FSK_MODE = 0;
  localparam int BIT_EXT_BAT = 1;
  localparam int BIT_IRQ_EN = 2;
  localparam int BIT_VARIANT = 3;
  // Status fields
  localparam int BIT_PENDING = 0;
  localparam int BIT_DONE = 1;
  localparam logic [7:0] ENH_RESET = 8'h00;
  // Implemented bits per variant
  localparam logic [7:0] MASK_GEN = 8'hf7;
  localparam logic [7:0] MASK_SEL = 8'hdd;
  // Indirect locations
  localparam logic [7:0] LOC_HYST_HI = 8'h1c;
  localparam logic [7:0] LOC_HYST_LO = 8'h2b;
  localparam logic [7:0] LOC_FSK_FIRST = 8'h63;
  localparam logic [7:0] LOC_TONE_ONE_FREQ_COEF_FIRST = 8'h0d;
  localparam int IND_DEPTH = 256;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int UPD_HZ = 16_000;
  localparam int UPD_CYC = CLK_HZ / UPD_HZ;
  localparam int TONE_SLOW_HZ = 8_000;
  localparam int TONE_FAST_HZ = 24_000;
  localparam int TONE_SLOW_CYC = CLK_HZ / TONE_SLOW_HZ;
  localparam int TONE_FAST_CYC = CLK_HZ / TONE_FAST_HZ;
  localparam int STEP_FAST_NS = 41_670;
  localparam int STEP_FAST_CYC = CLK_HZ / 1_000_000 * STEP_FAST_NS / 1000;
  localparam int DEBOUNCE_MS = 60;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam logic [7:0] BOOST_LIMIT_MA = 8'h29;
  localparam int BOOST_US = 10_000;
  localparam int BOOST_CYC = CLK_HZ / 1_000_000 * BOOST_US;
  typedef enum logic [1:0] {IND_IDLE = 2'b00, IND_WRITE = 2'b01, IND_READ = 2'b11} eia_ind_t;
  typedef struct packed {
    logic boost_active;
    logic tone_fast;
    logic use_fsk_coef;
    logic speedup_algo;
    logic ext_ref;
    logic debounce_on;
    logic closure_by_voltage;
    logic squelch_on;
    logic hyst_on;
  } eia_ctl_t;
endpackage : eia_pkg

// file: hw/eia_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module eia_top #(
  parameter int UPD_CYCLES = eia_pkg::UPD_CYC,
  parameter int DEBOUNCE_CYCLES = eia_pkg::DEBOUNCE_CYC,
  parameter int BOOST_CYCLES = eia_pkg::BOOST_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ring_burst_end,
  input wire logic closure_by_current,
  input wire logic closure_by_voltage_in,
  input wire logic closure_metric_above_hi,
  input wire logic closure_metric_below_lo,
  output logic [7:0] loop_current_limit,
  output logic tone_tick,
  output logic cadence_step,
  output logic [7:0] tone_coef_base,
  output eia_pkg::eia_ctl_t ctl,
  output logic battery_low_sel,
  output logic loop_closed,
  output logic [15:0] hyst_hi_thr,
  output logic [15:0] hyst_lo_thr,
  output logic indirect_done_irq
);
  logic [31:0] aw_q;
  logic s_axi_wstrb_q0;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [31:0] wdata_q, rdata_q;
  logic [7:0] enh_q, ctrl_q, loop_current_limit_q, iaddr_q;
  logic [15:0] idata_q, hi_q, lo_q;
  logic data_written_q, done_q, irq_q;
  eia_pkg::eia_ind_t st_q;
  logic [15:0] mem [eia_pkg::IND_DEPTH];
  logic [15:0] upd_cnt_q, tone_cnt_q, step_cnt_q;
  logic [23:0] deb_cnt_q, boost_cnt_q;
  logic bat_low_q, closed_q, bat_req_s1_q, bat_req_q, ext_s1_q, ext_q;

  wire wr_go = aw_full_q && w_full_q && !bvalid_q;
  wire [7:0] wa = aw_q[7:0];
  wire wr_enh = wr_go && wa == eia_pkg::ADDR_ENH;
  wire wr_idata = wr_go && wa == eia_pkg::ADDR_IDATA;
  wire wr_iaddr = wr_go && wa == eia_pkg::ADDR_IADDR;
  wire wr_status = wr_go && wa == eia_pkg::ADDR_STATUS;
  wire wr_ctrl = wr_go && wa == eia_pkg::ADDR_CTRL;
  wire wr_loop_current_limit = wr_go && wa == eia_pkg::ADDR_LOOP_CURRENT_LIMIT;
  wire wr_hit = wr_enh | wr_idata | wr_iaddr | wr_status | wr_ctrl | wr_loop_current_limit;
  wire variant_sel = ctrl_q[eia_pkg::BIT_VARIANT];
  wire [7:0] enh_mask = variant_sel ? eia_pkg::MASK_SEL : eia_pkg::MASK_GEN;
  wire upd_tick = upd_cnt_q == 16'(UPD_CYCLES - 1);
  wire fast_fsk = enh_q[eia_pkg::BIT_FSK] && ctrl_q[eia_pkg::BIT_FSK_MODE];
  wire pending = st_q != eia_pkg::IND_IDLE;
  wire ind_done = pending && upd_tick;
  wire done_clr = wr_status && wdata_q[eia_pkg::BIT_DONE];

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = 2'b00;

  logic [1:0] bresp_q;
  assign s_axi_bresp = bresp_q;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] e, input logic [15:0] d,
                                         input logic [7:0] ia, input logic p, input logic dn,
                                         input logic [7:0] c, input logic [7:0] il);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == eia_pkg::ADDR_ENH) r = {24'h00_0000, e};
    if (a == eia_pkg::ADDR_IDATA) r = {16'h0000, d};
    if (a == eia_pkg::ADDR_IADDR) r = {24'h00_0000, ia};
    if (a == eia_pkg::ADDR_STATUS) r = {30'h0000_0000, dn, p};
    if (a == eia_pkg::ADDR_CTRL) r = {24'h00_0000, c};
    if (a == eia_pkg::ADDR_LOOP_CURRENT_LIMIT) r = {24'h00_0000, il};
    return r;
  endfunction : rd_mux

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      aw_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_q <= {24'h00_0000, s_axi_awaddr};
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux(s_axi_araddr, enh_q, idata_q, iaddr_q, pending, done_q, ctrl_q, loop_current_limit_q);
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software registers; byte lane 0 carries all fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enh_q <= eia_pkg::ENH_RESET;
      ctrl_q <= 8'h00;
      loop_current_limit_q <= 8'h14;
    end else begin
      if (wr_enh && s_axi_wstrb_q0) enh_q <= wdata_q[7:0] & enh_mask;
      if (wr_ctrl && s_axi_wstrb_q0) ctrl_q <= wdata_q[7:0];
      if (wr_loop_current_limit && s_axi_wstrb_q0) loop_current_limit_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_axi_wstrb_q0 <= 1'b0;
    else if (s_axi_wvalid && !w_full_q) s_axi_wstrb_q0 <= s_axi_wstrb[0];
  end

  // Indirect request engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= eia_pkg::IND_IDLE;
      data_written_q <= 1'b0;
      done_q <= 1'b0;
      idata_q <= 16'h0000;
      iaddr_q <= 8'h00;
      upd_cnt_q <= 16'h0000;
    end else begin
      upd_cnt_q <= upd_tick ? 16'h0000 : upd_cnt_q + 16'h0001;
      if (wr_idata) begin
        idata_q <= wdata_q[15:0];
        data_written_q <= 1'b1;
      end
      if (wr_iaddr && !pending) begin
        iaddr_q <= wdata_q[7:0];
        st_q <= data_written_q ? eia_pkg::IND_WRITE : eia_pkg::IND_READ;
        data_written_q <= 1'b0;
      end
      if (ind_done) begin
        st_q <= eia_pkg::IND_IDLE;
        if (st_q == eia_pkg::IND_READ) idata_q <= mem[iaddr_q];
      end
      if (ind_done) done_q <= 1'b1;
      else if (done_clr) done_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (ind_done && st_q == eia_pkg::IND_WRITE) mem[iaddr_q] <= idata_q;
    if (ind_done && st_q == eia_pkg::IND_WRITE && iaddr_q == eia_pkg::LOC_HYST_HI) hi_q <= idata_q;
    if (ind_done && st_q == eia_pkg::IND_WRITE && iaddr_q == eia_pkg::LOC_HYST_LO) lo_q <= idata_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_q <= 1'b0;
    else irq_q <= done_q && ctrl_q[eia_pkg::BIT_IRQ_EN];
  end
  assign indirect_done_irq = irq_q;

  // Tone clock and cadence step
  wire [15:0] tone_div = fast_fsk ? 16'(eia_pkg::TONE_FAST_CYC - 1) : 16'(eia_pkg::TONE_SLOW_CYC - 1);
  wire [15:0] step_div = fast_fsk ? 16'(eia_pkg::STEP_FAST_CYC - 1) : 16'(eia_pkg::TONE_SLOW_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_cnt_q <= 16'h0000;
      step_cnt_q <= 16'h0000;
      tone_tick <= 1'b0;
      cadence_step <= 1'b0;
    end else begin
      tone_tick <= tone_cnt_q >= tone_div;
      tone_cnt_q <= (tone_cnt_q >= tone_div) ? 16'h0000 : tone_cnt_q + 16'h0001;
      cadence_step <= step_cnt_q >= step_div;
      step_cnt_q <= (step_cnt_q >= step_div) ? 16'h0000 : step_cnt_q + 16'h0001;
    end
  end

  // Current limit boost after ring burst
  always_ff @(posedge aclk) begin
    if (!aresetn) boost_cnt_q <= 24'h00_0000;
    else if (ring_burst_end && enh_q[eia_pkg::BIT_BOOST]) boost_cnt_q <= 24'(BOOST_CYCLES);
    else if (boost_cnt_q != 24'h00_0000) boost_cnt_q <= boost_cnt_q - 24'h00_0001;
  end

  // Battery switch: high-to-low debounced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bat_req_s1_q <= 1'b0;
      bat_req_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_q <= 1'b0;
      bat_low_q <= 1'b0;
      deb_cnt_q <= 24'h00_0000;
    end else begin
      bat_req_s1_q <= closure_metric_below_lo;
      bat_req_q <= bat_req_s1_q;
      ext_s1_q <= ctrl_q[eia_pkg::BIT_EXT_BAT];
      ext_q <= ext_s1_q;
      if (!bat_req_q) begin
        bat_low_q <= 1'b0;
        deb_cnt_q <= 24'h00_0000;
      end else if (!(ext_q && enh_q[eia_pkg::BIT_DEBOUNCE])) begin
        bat_low_q <= 1'b1;
      end else if (deb_cnt_q >= 24'(DEBOUNCE_CYCLES - 1)) begin
        bat_low_q <= 1'b1;
      end else begin
        deb_cnt_q <= deb_cnt_q + 24'h00_0001;
      end
    end
  end

  // Loop-closure decision
  wire raw_closed = enh_q[eia_pkg::BIT_VLC] ? closure_by_voltage_in : closure_by_current;
  always_ff @(posedge aclk) begin
    if (!aresetn) closed_q <= 1'b0;
    else if (!enh_q[eia_pkg::BIT_HYST]) closed_q <= raw_closed;
    else if (closure_metric_above_hi) closed_q <= 1'b1;
    else if (closure_metric_below_lo) closed_q <= 1'b0;
  end

  assign loop_current_limit = (boost_cnt_q != 24'h00_0000) ? eia_pkg::BOOST_LIMIT_MA : loop_current_limit_q;
  assign tone_coef_base = fast_fsk ? eia_pkg::LOC_FSK_FIRST : eia_pkg::LOC_TONE_ONE_FREQ_COEF_FIRST;
  assign ctl = '{boost_active: boost_cnt_q != 24'h00_0000, tone_fast: fast_fsk, use_fsk_coef: fast_fsk,
                 speedup_algo: enh_q[eia_pkg::BIT_SPEEDUP],
                 ext_ref: enh_q[eia_pkg::BIT_EXTREF],
                 debounce_on: enh_q[eia_pkg::BIT_DEBOUNCE],
                 closure_by_voltage: enh_q[eia_pkg::BIT_VLC],
                 squelch_on: enh_q[eia_pkg::BIT_SQUELCH],
                 hyst_on: enh_q[eia_pkg::BIT_HYST]};
  assign battery_low_sel = bat_low_q;
  assign loop_closed = closed_q;
  assign hyst_hi_thr = hi_q;
  assign hyst_lo_thr = lo_q;

  AST_PEND_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    pending && upd_tick |=> !pending) else $error("pending not cleared on tick");
  AST_REQ_SETS_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_iaddr && !pending && !upd_tick |=> pending) else $error("request not pending");
  AST_ONLY_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    pending && !upd_tick && !wr_iaddr |=> pending) else $error("serviced off tick");
  AST_DONE_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    ind_done |=> done_q) else $error("done not set");
  AST_ENH_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_enh && s_axi_wstrb_q0 |=> (enh_q & ~$past(enh_mask)) == 8'h00) else $error("reserved bit set");
  AST_BOOST: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_burst_end && enh_q[eia_pkg::BIT_BOOST] |=> loop_current_limit == eia_pkg::BOOST_LIMIT_MA)
    else $error("boost missing");
  AST_NO_BOOST: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_burst_end && !enh_q[eia_pkg::BIT_BOOST] && boost_cnt_q == 24'h00_0000 |=> loop_current_limit == loop_current_limit_q)
    else $error("limit not programmed");
  AST_COEF: assert property (@(posedge aclk) disable iff (!aresetn)
    !fast_fsk |-> tone_coef_base == eia_pkg::LOC_TONE_ONE_FREQ_COEF_FIRST) else $error("wrong coef");
  AST_VLC: assert property (@(posedge aclk) disable iff (!aresetn)
    !enh_q[eia_pkg::BIT_HYST] && enh_q[eia_pkg::BIT_VLC] |=> closed_q == $past(closure_by_voltage_in))
    else $error("closure source wrong");
  AST_CUR_CLOSE: assert property (@(posedge aclk) disable iff (!aresetn)
    !enh_q[eia_pkg::BIT_HYST] && !enh_q[eia_pkg::BIT_VLC] |=> closed_q == $past(closure_by_current))
    else $error("current closure wrong");
  AST_HYST_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    enh_q[eia_pkg::BIT_HYST] && closure_metric_above_hi |=> loop_closed)
    else $error("upper threshold ignored");
  AST_HYST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    enh_q[eia_pkg::BIT_HYST] && !closure_metric_above_hi && !closure_metric_below_lo |=> loop_closed == $past(loop_closed))
    else $error("hysteresis not held");
  AST_DEB_NOW: assert property (@(posedge aclk) disable iff (!aresetn)
    bat_req_q && !(ext_q && enh_q[eia_pkg::BIT_DEBOUNCE]) |=> battery_low_sel)
    else $error("undebounced switch late");
  AST_DEB_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bat_req_q) && ext_q && enh_q[eia_pkg::BIT_DEBOUNCE] |=> !battery_low_sel)
    else $error("debounce skipped");
  AST_BAT_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    !bat_req_q |=> !battery_low_sel)
    else $error("low-to-high switch delayed");
  AST_WRITE_LANDS: assert property (@(posedge aclk) disable iff (!aresetn)
    ind_done && st_q == eia_pkg::IND_WRITE |=> mem[iaddr_q] == $past(idata_q))
    else $error("indirect write lost");
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    done_q && ctrl_q[eia_pkg::BIT_IRQ_EN] |=> indirect_done_irq)
    else $error("done interrupt missing");
  COV_WRITE: cover property (@(posedge aclk) ind_done && st_q == eia_pkg::IND_WRITE);
  COV_READ: cover property (@(posedge aclk) ind_done && st_q == eia_pkg::IND_READ);
  COV_FAST: cover property (@(posedge aclk) fast_fsk && tone_tick);
  COV_DEBOUNCE: cover property (@(posedge aclk) ext_q && enh_q[eia_pkg::BIT_DEBOUNCE] && $rose(bat_low_q));
  COV_HYST: cover property (@(posedge aclk) enh_q[eia_pkg::BIT_HYST] && closure_metric_above_hi);
endmodule : eia_top

// file: tb/eia_host.sv
`timescale 1ns/1ps
module eia_host (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ad;
    ad = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        break;
      end
    end
    rready <= 1'b0;
  endtask : rd
endmodule : eia_host

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, loop_current_limit, tone_coef_base;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tone_tick, cadence_step, battery_low_sel, loop_closed, indirect_done_irq;
  logic [15:0] hyst_hi_thr, hyst_lo_thr;
  eia_pkg::eia_ctl_t ctl;
  logic ring_burst_end = 1'b0;
  logic closure_by_current = 1'b0;
  logic closure_by_voltage_in = 1'b1;
  logic closure_metric_above_hi = 1'b0;
  logic closure_metric_below_lo = 1'b0;
  int num_errors = 0;
  int cmp_count = 0;

  eia_top #(.UPD_CYCLES(64), .DEBOUNCE_CYCLES(20), .BOOST_CYCLES(10)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ring_burst_end, .closure_by_current, .closure_by_voltage_in, .closure_metric_above_hi,
    .closure_metric_below_lo, .loop_current_limit, .tone_tick, .cadence_step, .tone_coef_base, .ctl,
    .battery_low_sel, .loop_closed, .hyst_hi_thr, .hyst_lo_thr, .indirect_done_irq);

  eia_host host_u (.aclk(aclk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic st(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : st

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    host_u.wr(a, d, br);
    `CHK(br, 2'b00)
    st(1);
  endtask : w

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host_u.rd(a, d);
    `CHK(d, e)
    `CHK(s_axi_rresp, 2'b00)
    st(1);
  endtask : rc

  task automatic pulse;
    @(posedge aclk);
    ring_burst_end <= 1'b1;
    @(posedge aclk);
    ring_burst_end <= 1'b0;
  endtask : pulse

  // Cycles between two consecutive pulses
  task automatic gap(input bit s, input int e);
    int n;
    n = 1;
    @(posedge aclk);
    while ((s ? cadence_step : tone_tick) !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    while ((s ? cadence_step : tone_tick) !== 1'b1) begin
      n++;
      @(posedge aclk);
    end
    `CHK(n, e)
    st(1);
  endtask : gap

  // Host waits for completion before the next access
  task automatic idone;
    while (indirect_done_irq !== 1'b1) @(posedge aclk);
    st(1);
    rc(eia_pkg::ADDR_STATUS, 32'h0000_0002);
    w(eia_pkg::ADDR_STATUS, 32'h0000_0002);
    st(2);
    `CHK(indirect_done_irq, 1'b0)
  endtask : idone

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st(1);
    rc(eia_pkg::ADDR_ENH, 32'h0000_0000);
    w(eia_pkg::ADDR_ENH, 32'h0000_00ff);
    rc(eia_pkg::ADDR_ENH, {24'h00_0000, eia_pkg::MASK_GEN});
    `CHK(ctl.speedup_algo, 1'b1)
    `CHK(ctl.squelch_on, 1'b1)
    `CHK(ctl.ext_ref, 1'b1)
    `CHK(ctl.hyst_on, 1'b1)
    `CHK(ctl.debounce_on, 1'b0)
    w(eia_pkg::ADDR_CTRL, 32'h0000_0008);
    w(eia_pkg::ADDR_ENH, 32'h0000_00ff);
    rc(eia_pkg::ADDR_ENH, {24'h00_0000, eia_pkg::MASK_SEL});
    `CHK(ctl.speedup_algo, 1'b0)
    `CHK(ctl.squelch_on, 1'b0)
    host_u.wr(8'h90, 32'h0000_0001, br);
    `CHK(br, 2'b10)
    rc(8'h90, 32'h0000_0000);
    $display("test registers done");
    w(eia_pkg::ADDR_ENH, 32'h0000_0004);
    st(4);
    `CHK(loop_closed, 1'b1)
    w(eia_pkg::ADDR_ENH, 32'h0000_0000);
    st(4);
    `CHK(loop_closed, 1'b0)
    $display("test closure done");
    w(eia_pkg::ADDR_LOOP_CURRENT_LIMIT, 32'h0000_0020);
    pulse();
    st(1);
    `CHK(loop_current_limit, 8'h20)
    w(eia_pkg::ADDR_ENH, 32'h0000_0080);
    pulse();
    st(1);
    `CHK(loop_current_limit, eia_pkg::BOOST_LIMIT_MA)
    st(13);
    `CHK(loop_current_limit, 8'h20)
    $display("test boost done");
    w(eia_pkg::ADDR_CTRL, 32'h0000_0001);
    w(eia_pkg::ADDR_ENH, 32'h0000_0040);
    `CHK(tone_coef_base, eia_pkg::LOC_FSK_FIRST)
    gap(1'b0, eia_pkg::TONE_FAST_CYC);
    gap(1'b1, eia_pkg::STEP_FAST_CYC);
    w(eia_pkg::ADDR_CTRL, 32'h0000_0000);
    `CHK(tone_coef_base, eia_pkg::LOC_TONE_ONE_FREQ_COEF_FIRST)
    gap(1'b0, eia_pkg::TONE_SLOW_CYC);
    $display("test tone done");
    w(eia_pkg::ADDR_CTRL, 32'h0000_000a);
    w(eia_pkg::ADDR_ENH, 32'h0000_0008);
    `CHK(ctl.debounce_on, 1'b1)
    @(posedge aclk);
    closure_metric_below_lo <= 1'b1;
    st(10);
    `CHK(battery_low_sel, 1'b0)
    st(15);
    `CHK(battery_low_sel, 1'b1)
    @(posedge aclk);
    closure_metric_below_lo <= 1'b0;
    st(4);
    `CHK(battery_low_sel, 1'b0)
    w(eia_pkg::ADDR_ENH, 32'h0000_0001);
    @(posedge aclk);
    closure_metric_below_lo <= 1'b1;
    st(4);
    `CHK(battery_low_sel, 1'b1)
    `CHK(loop_closed, 1'b0)
    @(posedge aclk);
    closure_metric_below_lo <= 1'b0;
    closure_metric_above_hi <= 1'b1;
    st(2);
    `CHK(loop_closed, 1'b1)
    @(posedge aclk);
    closure_metric_above_hi <= 1'b0;
    st(4);
    `CHK(loop_closed, 1'b1)
    @(posedge aclk);
    closure_metric_below_lo <= 1'b1;
    st(2);
    `CHK(loop_closed, 1'b0)
    @(posedge aclk);
    closure_metric_below_lo <= 1'b0;
    st(4);
    `CHK(battery_low_sel, 1'b0)
    $display("test battery and hysteresis done");
    w(eia_pkg::ADDR_CTRL, 32'h0000_0004);
    w(eia_pkg::ADDR_IADDR, {24'h00_0000, eia_pkg::LOC_HYST_LO});
    idone();
    w(eia_pkg::ADDR_IDATA, 32'h0000_1234);
    w(eia_pkg::ADDR_IADDR, {24'h00_0000, eia_pkg::LOC_HYST_HI});
    rc(eia_pkg::ADDR_STATUS, 32'h0000_0001);
    idone();
    `CHK(hyst_hi_thr, 16'h1234)
    w(eia_pkg::ADDR_IDATA, 32'h0000_5555);
    w(eia_pkg::ADDR_IADDR, {24'h00_0000, eia_pkg::LOC_HYST_LO});
    idone();
    `CHK(hyst_lo_thr, 16'h5555)
    w(eia_pkg::ADDR_IADDR, {24'h00_0000, eia_pkg::LOC_HYST_HI});
    rc(eia_pkg::ADDR_STATUS, 32'h0000_0001);
    idone();
    rc(eia_pkg::ADDR_IDATA, 32'h0000_1234);
    $display("test indirect done");
    summarize();
  end
endmodule : tb_top
